// *** rtl/evpu_top.v ***
// Exception vectoring, priority arbitration and preemption decision
`timescale 1ns/1ps
`include "evpu_defs.vh"

// How it works
// - handler slot offset is four times number
// - peripheral number is bit position; reserved unsourced
// - table holds stack pointer then handler addresses
// - reset fetches from table at address zero
// - base register writable only when privileged
// - lower value more urgent; two fixed exceptions
// - every configurable priority resets to zero
// - configurable priorities limited to zero through seven
// - equal priority picks smallest exception number
// - strictly more urgent arrival preempts running handler
// - equal priority never preempts; stays pending
// - NMI always enabled, fixed above all but reset
// - hard fault fixed above every configurable exception
// - reset stack pointer from entry zero
module evpu_top (
   // Clock, reset, enable
   input wire clk,
   input wire reset_n,
   input wire ce,
   // Register port
   input wire [7:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire reg_priv,
   output reg [31:0] reg_rdata_r,
   // Exception sources
   input wire [43:0] irq_in,
   input wire [15:0] sys_req_in,
   // Core side
   input wire exc_ack,
   input wire exc_ret,
   output reg exc_req_r,
   output reg [5:0] exc_num_r,
   output reg [31:0] vec_addr_r,
   output reg [31:0] sp_addr_r,
   output reg [5:0] run_num_r,
   output reg run_valid_r,
   // Interrupt out
   output wire irq_o
);

   localparam N = `EVPU_NEXC;

   // Register map, byte offsets on reg_addr
   //   base word: table base bits 29:8, privileged write only
   //   enable words: one bit per peripheral source, reserved bits stay zero
   //   pend words: read pending sources, writing a one sets pending
   //   status word: running number and level, winner number and valid
   //   event word: sticky events, write one to clear
   //   event mask word: same layout, selects events onto irq_o
   //   priority page: eight exceptions per word, one nibble each
   //
   // Core handshake
   //   exc_req_r offers exc_num_r with its vector in vec_addr_r
   //   exc_ack with exc_req_r high enters it: pending drops, active rises
   //   exc_ret ends the most urgent active handler
   //   a forced bubble follows every entry, so one offer is never taken twice
   //
   // Limitation: pending is edge-set only; a source held high pends once

   // Peripheral sources that exist; reserved numbers never enable
   wire [43:0] irq_ok = ~`EVPU_IRQ_RSVD;

   // Handler slot address from base and exception number
   function [31:0] vec_addr;
      input [21:0] base;
      input [5:0] num;
      begin
         vec_addr = {2'b00, base, num, 2'b00};
      end
   endfunction

   // Urgency level of an exception, fixed ones below the configurable band
   function [3:0] lvl_of;
      input [5:0] num;
      input [2:0] pri;
      begin
         case (num)
            `EVPU_EXC_NMI: lvl_of = `EVPU_LVL_NMI;
            `EVPU_EXC_HARD: lvl_of = `EVPU_LVL_HARD;
            default: lvl_of = `EVPU_LVL_CFG0 + {1'b0, pri};
         endcase
      end
   endfunction

   wire [N-1:0] valid_mask = {~`EVPU_IRQ_RSVD, `EVPU_SYS_VALID};
   wire [N-1:0] cfg_mask = {~`EVPU_IRQ_RSVD, `EVPU_SYS_CFG};
   wire [N-1:0] src = {irq_in, sys_req_in};

   reg [2:0] pri_r [0:N-1];
   reg [21:0] vtor_r;
   reg [31:0] en0_r;
   reg [11:0] en1_r;
   reg [`EVPU_IW-1:0] istat_r;
   reg [`EVPU_IW-1:0] imask_r;
   reg [N-1:0] src_prev_r;

   wire [N-1:0] pend_r;
   wire [N-1:0] act_r;
   reg [N-1:0] sw_set;
   reg [N-1:0] pend_clr;
   reg [N-1:0] act_set;
   reg [N-1:0] act_clr;
   reg [N*4-1:0] lvl_flat;
   reg [N-1:0] same_lvl;
   reg [`EVPU_IW-1:0] ev;
   reg [31:0] rd_nxt;
   reg exc_req_nxt;
   integer i;
   integer j;

   wire win_valid;
   wire [5:0] win_num;
   wire [3:0] win_level;
   wire act_valid;
   wire [5:0] act_num;
   wire [3:0] act_level;

   // Rising edge of a source marks it pending
   wire [N-1:0] src_rise = src & ~src_prev_r & valid_mask;
   wire [N-1:0] pend_set = src_rise | (sw_set & valid_mask);

   // System exceptions are never gated; NMI can't be masked
   wire [N-1:0] enabled = {en1_r, en0_r, {`EVPU_NSYS{1'b1}}};
   wire [N-1:0] arb_req = pend_r & enabled & valid_mask;

   wire wr_pri = reg_wr && (reg_addr[7:5] == `EVPU_PRI_PAGE) && (reg_addr[1:0] == 2'b00);
   wire rd_pri = reg_addr[7:5] == `EVPU_PRI_PAGE;

   // Level vector for both arbiters, and same-level match with the runner
   always @* begin
      lvl_flat = {N*4{1'b0}};
      same_lvl = {N{1'b0}};
      for (i = 0; i < N; i = i + 1) begin
         lvl_flat[i*4 +: 4] = lvl_of(i[5:0], pri_r[i]);
         same_lvl[i] = lvl_flat[i*4 +: 4] == act_level;
      end
   end

   // Flag updates from the core handshake and software pend writes
   always @* begin
      sw_set = {N{1'b0}};
      pend_clr = {N{1'b0}};
      act_set = {N{1'b0}};
      act_clr = {N{1'b0}};
      if (reg_wr && reg_addr == `EVPU_OFF_PEND0) begin
         sw_set[47:16] = reg_wdata;
      end
      if (reg_wr && reg_addr == `EVPU_OFF_PEND1) begin
         sw_set[59:48] = reg_wdata[11:0];
      end
      if (exc_ack && exc_req_r) begin
         pend_clr[exc_num_r] = 1'b1;
         act_set[exc_num_r] = 1'b1;
      end
      // The most urgent active handler is the one that returns
      if (exc_ret && act_valid) begin
         act_clr[act_num] = 1'b1;
      end
   end

   evpu_flags #(.W(N)) u_pend (
      .clk(clk),
      .reset_n(reset_n),
      .ce(ce),
      .set(pend_set),
      .clr(pend_clr),
      .flags_r(pend_r)
   );

   evpu_flags #(.W(N)) u_act (
      .clk(clk),
      .reset_n(reset_n),
      .ce(ce),
      .set(act_set),
      .clr(act_clr),
      .flags_r(act_r)
   );

   evpu_arb #(.N(N), .LW(4)) u_win (
      .req(arb_req),
      .lvl(lvl_flat),
      .valid(win_valid),
      .num(win_num),
      .level(win_level)
   );

   evpu_arb #(.N(N), .LW(4)) u_run (
      .req(act_r),
      .lvl(lvl_flat),
      .valid(act_valid),
      .num(act_num),
      .level(act_level)
   );

   // Preempt only on strictly more urgent; bubble after an ack so a stale
   // request is never offered twice
   always @* begin
      exc_req_nxt = win_valid && (!act_valid || win_level < act_level)
         && !(exc_ack && exc_req_r);
   end

   // Event sources for the sticky status
   always @* begin
      ev = {`EVPU_IW{1'b0}};
      ev[`EVPU_EV_NEST] = exc_ack && exc_req_r && act_valid;
      ev[`EVPU_EV_REFUSED] = reg_wr && reg_addr == `EVPU_OFF_VTOR && !reg_priv;
      ev[`EVPU_EV_SAMEPEND] = act_valid && |(pend_set & same_lvl);
   end

   // Core-facing outputs, all from flops
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         exc_req_r <= 1'b0;
         exc_num_r <= 6'h00;
         vec_addr_r <= 32'h00000000;
         sp_addr_r <= 32'h00000000;
         run_num_r <= 6'h00;
         run_valid_r <= 1'b0;
         src_prev_r <= {N{1'b0}};
      end else if (ce) begin
         exc_req_r <= exc_req_nxt;
         exc_num_r <= win_num;
         vec_addr_r <= vec_addr(vtor_r, win_num);
         sp_addr_r <= vec_addr(vtor_r, `EVPU_EXC_SP);
         run_num_r <= act_num;
         run_valid_r <= act_valid;
         src_prev_r <= src;
      end
   end

   // Software-written registers
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         vtor_r <= `EVPU_VTOR_RST;
         en0_r <= 32'h00000000;
         en1_r <= 12'h000;
         imask_r <= {`EVPU_IW{1'b0}};
         for (i = 0; i < N; i = i + 1) begin
            pri_r[i] <= `EVPU_PRI_RST;
         end
      end else if (ce && reg_wr) begin
         // Low byte of the base is not stored, so any value is 256-byte aligned
         if (reg_addr == `EVPU_OFF_VTOR && reg_priv) begin
            vtor_r <= reg_wdata[`EVPU_VTOR_MSB:`EVPU_VTOR_LSB];
         end
         if (reg_addr == `EVPU_OFF_EN0) begin
            // Low word covers sources 0 to 31
            en0_r <= reg_wdata & irq_ok[31:0];
         end
         if (reg_addr == `EVPU_OFF_EN1) begin
            // High word covers sources 32 to 43 only
            en1_r <= reg_wdata[11:0] & irq_ok[43:32];
         end
         if (reg_addr == `EVPU_OFF_IMASK) begin
            imask_r <= reg_wdata[`EVPU_IW-1:0];
         end
         // Eight three-bit priorities per word, one per nibble
         if (wr_pri) begin
            for (j = 0; j < 8; j = j + 1) begin
               if (({1'b0, reg_addr[4:2], j[2:0]} < N) &&
                   cfg_mask[{reg_addr[4:2], j[2:0]}]) begin
                  pri_r[{reg_addr[4:2], j[2:0]}] <= reg_wdata[j*4 +: 3];
               end
            end
         end
      end
   end

   // Sticky events, write one to clear; a new event wins over the clear
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         istat_r <= {`EVPU_IW{1'b0}};
      end else if (ce) begin
         if (reg_wr && reg_addr == `EVPU_OFF_ISTAT) begin
            istat_r <= (istat_r & ~reg_wdata[`EVPU_IW-1:0]) | ev;
         end else begin
            istat_r <= istat_r | ev;
         end
      end
   end

   assign irq_o = |(istat_r & imask_r);

   // Read mux; unmapped offsets read zero
   // Status word is live, so a read shows the state at the strobe edge
   always @* begin
      rd_nxt = 32'h00000000;
      if (rd_pri) begin
         for (j = 0; j < 8; j = j + 1) begin
            if ({1'b0, reg_addr[4:2], j[2:0]} < N) begin
               rd_nxt[j*4 +: 3] = pri_r[{reg_addr[4:2], j[2:0]}];
            end
         end
      end else begin
         case (reg_addr)
            `EVPU_OFF_VTOR: rd_nxt = {2'b00, vtor_r, 8'h00};
            `EVPU_OFF_EN0: rd_nxt = en0_r;
            `EVPU_OFF_EN1: rd_nxt = {20'h00000, en1_r};
            `EVPU_OFF_PEND0: rd_nxt = pend_r[47:16];
            `EVPU_OFF_PEND1: rd_nxt = {20'h00000, pend_r[59:48]};
            `EVPU_OFF_STAT: rd_nxt = {8'h00, act_valid, win_valid, win_num,
               4'h0, act_level, 2'b00, act_num};
            `EVPU_OFF_ISTAT: rd_nxt = {29'h00000000, istat_r};
            `EVPU_OFF_IMASK: rd_nxt = {29'h00000000, imask_r};
            default: rd_nxt = 32'h00000000;
         endcase
      end
   end

   // Read data stand only in the cycle after the strobe
   // Zero outside that cycle keeps a stale word from being mistaken for data
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata_r <= 32'h00000000;
      end else if (ce) begin
         reg_rdata_r <= reg_rd ? rd_nxt : 32'h00000000;
      end
   end

endmodule

// *** rtl/evpu_defs.vh ***
// Shared constants for the exception vector and priority unit
`ifndef EVPU_DEFS_VH
`define EVPU_DEFS_VH

// Exception numbering
`define EVPU_NEXC 60
`define EVPU_NIRQ 44
`define EVPU_NSYS 16
`define EVPU_EXC_SP 6'h00
`define EVPU_EXC_NMI 6'h02
`define EVPU_EXC_HARD 6'h03

// Source masks: reserved peripheral numbers, implemented system exceptions
`define EVPU_IRQ_RSVD 44'h6660003d240
`define EVPU_SYS_VALID 16'hd87c
`define EVPU_SYS_CFG 16'hd870

// Urgency levels, lower is more urgent; configurable ones start above hard fault
`define EVPU_LVL_NMI 4'h1
`define EVPU_LVL_HARD 4'h2
`define EVPU_LVL_CFG0 4'h3
`define EVPU_PRI_RST 3'h0

// Vector base field, 256-byte granule
`define EVPU_VTOR_MSB 29
`define EVPU_VTOR_LSB 8
`define EVPU_VTOR_RST 22'h000000

// Register byte offsets
`define EVPU_OFF_VTOR 8'h00
`define EVPU_OFF_EN0 8'h04
`define EVPU_OFF_EN1 8'h08
`define EVPU_OFF_PEND0 8'h0c
`define EVPU_OFF_PEND1 8'h10
`define EVPU_OFF_STAT 8'h14
`define EVPU_OFF_ISTAT 8'h18
`define EVPU_OFF_IMASK 8'h1c
`define EVPU_PRI_PAGE 3'h1

// Event status bits
`define EVPU_IW 3
`define EVPU_EV_NEST 0
`define EVPU_EV_REFUSED 1
`define EVPU_EV_SAMEPEND 2

`endif

// *** rtl/evpu_flags.v ***
// Bank of sticky per-exception flags with set winning over clear
`timescale 1ns/1ps
module evpu_flags #(
   parameter W = 60
) (
   // Clock and reset
   input wire clk,
   input wire reset_n,
   input wire ce,
   // Flag updates
   input wire [W-1:0] set,
   input wire [W-1:0] clr,
   // Flag state
   output reg [W-1:0] flags_r
);

   // A set arriving with its clear keeps the flag
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         flags_r <= {W{1'b0}};
      end else if (ce) begin
         flags_r <= (flags_r & ~clr) | set;
      end
   end

endmodule

// *** rtl/evpu_arb.v ***
// Most urgent request finder, ties go to the lowest number
`timescale 1ns/1ps
module evpu_arb #(
   parameter N = 60,
   parameter LW = 4
) (
   // Requests and their levels
   input wire [N-1:0] req,
   input wire [N*LW-1:0] lvl,
   // Winner
   output reg valid,
   output reg [5:0] num,
   output reg [LW-1:0] level
);

   integer i;
   reg [LW-1:0] cur;

   // Scan downward so a tie on level lands on the smaller number
   always @* begin
      valid = 1'b0;
      num = 6'h00;
      level = {LW{1'b1}};
      cur = {LW{1'b0}};
      for (i = N - 1; i >= 0; i = i - 1) begin
         cur = lvl[i*LW +: LW];
         if (req[i] && (!valid || cur <= level)) begin
            valid = 1'b1;
            num = i[5:0];
            level = cur;
         end
      end
   end

endmodule

// *** dv/evpu_core_model.sv ***
// Behavioural core that takes offered exceptions and ends handlers
`timescale 1ns/1ps
module evpu_core_model (
   // Clock and reset
   input wire clk,
   input wire reset_n,
   // Bench controls
   input wire ack_en,
   input wire ret_go,
   // Unit side
   input wire exc_req_r,
   output logic exc_ack,
   output logic exc_ret
);
   // One ack per offer; slow answers come from the bench holding ack_en low
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         exc_ack <= 1'b0;
         exc_ret <= 1'b0;
      end else begin
         exc_ack <= exc_req_r && ack_en && !exc_ack;
         exc_ret <= ret_go;
      end
   end
endmodule

// *** dv/evpu_top_sva.sv ***
// Port checker for the exception vector and priority unit
`timescale 1ns/1ps
module evpu_top_sva (
   // Clock and reset
   input wire clk,
   input wire reset_n,
   // Register port
   input wire [7:0] reg_addr,
   input wire reg_wr,
   input wire reg_priv,
   // Sources and core side
   input wire [15:0] sys_req_in,
   input wire exc_ack,
   input wire exc_req_r,
   input wire [5:0] exc_num_r,
   input wire [31:0] vec_addr_r,
   input wire [31:0] sp_addr_r,
   input wire [5:0] run_num_r,
   input wire run_valid_r
);
   // Privileged base write; sp_addr_r may follow one or two edges later
   wire base_wr = reg_wr && reg_priv && reg_addr == 8'h00;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_slot_offset: assert property (
      exc_req_r |-> vec_addr_r[7:0] == {exc_num_r, 2'b00}) else $error("slot offset wrong");
   a_base_shared: assert property (
      exc_req_r |-> vec_addr_r[31:8] == sp_addr_r[31:8] && sp_addr_r[7:0] == 8'h00)
      else $error("vector base wrong");
   a_no_reserved: assert property (
      exc_req_r |-> !(exc_num_r inside {[0:1], [7:10], 13, 22, 25, 28, [30:33], 49, 50,
      53, 54, 57, 58})) else $error("unsourced number offered");
   a_entry_bubble: assert property (
      exc_ack && exc_req_r |=> !exc_req_r ##1 (run_valid_r && run_num_r == $past(exc_num_r, 2)))
      else $error("entry sequence wrong");
   a_nmi_locked: assert property (
      run_valid_r && run_num_r == 6'h02 |-> !exc_req_r) else $error("nmi preempted");
   a_hard_locked: assert property (
      run_valid_r && run_num_r == 6'h03 |-> !exc_req_r || exc_num_r == 6'h02)
      else $error("hard fault preempted");
   a_nmi_first: assert property (
      $rose(sys_req_in[2]) && !(run_valid_r && run_num_r == 6'h02)
      |-> ##[2:4] (exc_req_r && exc_num_r == 6'h02)) else $error("nmi not offered");
   a_base_priv: assert property (
      $changed(sp_addr_r) |-> $past(base_wr, 1) || $past(base_wr, 2))
      else $error("base moved without privileged write");
   c_nested: cover property (exc_ack && exc_req_r && run_valid_r);
   c_nmi_run: cover property (run_valid_r && run_num_r == 6'h02);
   c_hard_run: cover property (run_valid_r && run_num_r == 6'h03);
endmodule

// *** dv/evpu_top_tb.sv ***
// Self-checking bench for the exception vector and priority unit
`timescale 1ns/1ps
module evpu_top_tb;
   logic clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, reg_priv = 0, ack_en = 0, ret_go = 0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, base = 32'h0;
   logic [43:0] irq_in = 44'h0;
   logic [15:0] sys_req_in = 16'h0;
   logic exc_ack, exc_ret, exc_req_r, run_valid_r, irq_o;
   logic [5:0] exc_num_r, run_num_r;
   logic [31:0] reg_rdata_r, vec_addr_r, sp_addr_r;
   int failures = 0, check_count = 0;
   initial forever #25 clk = ~clk;
   evpu_top u_evpu_top (.clk, .reset_n, .ce(1'b1), .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_priv, .reg_rdata_r, .irq_in, .sys_req_in, .exc_ack, .exc_ret, .exc_req_r,
      .exc_num_r, .vec_addr_r, .sp_addr_r, .run_num_r, .run_valid_r, .irq_o);
   evpu_core_model u_evpu_core_model (.clk, .reset_n, .ack_en, .ret_go, .exc_req_r, .exc_ack,
      .exc_ret);
   task automatic finish_test();
      $display("checks %0d, failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
         failures++;
      end
   endtask
   // Bus cycles: one strobe cycle, read data looked at in the next cycle only
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(negedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      chk("read data", e, reg_rdata_r);
   endtask
   task automatic pulse(input logic [43:0] i, input logic [15:0] s);
      @(posedge clk);
      irq_in <= i;
      sys_req_in <= s;
      @(posedge clk);
      irq_in <= 44'h0;
      sys_req_in <= 16'h0;
   endtask
   // Bounded waits; running out counts a mismatch and ends the run
   task automatic offer(input logic [5:0] n);
      int i;
      for (i = 0; i < 8 && exc_req_r !== 1'b1; i++) @(negedge clk);
      if (i == 8) begin
         failures++;
         finish_test();
      end
      chk("offered number", {26'h0, n}, {26'h0, exc_num_r});
      chk("vector address", base + {24'h0, n, 2'b00}, vec_addr_r);
      chk("vector word aligned", 32'h0, {30'h0, vec_addr_r[1:0]});
   endtask
   task automatic take(input logic [5:0] n);
      int i;
      @(posedge clk);
      ack_en <= 1'b1;
      for (i = 0; i < 8 && !(run_valid_r === 1'b1 && run_num_r === n); i++) @(posedge clk);
      ack_en <= 1'b0;
      if (i == 8) begin
         failures++;
         finish_test();
      end
   endtask
   task automatic none();
      repeat (6) begin
         @(negedge clk);
         chk("request idle", 32'h0, {31'h0, exc_req_r});
      end
   endtask
   task automatic ret();
      @(posedge clk);
      ret_go <= 1'b1;
      @(posedge clk);
      ret_go <= 1'b0;
      repeat (3) @(negedge clk);
   endtask
   task automatic t_reset();
      rd(8'h00, 32'h0);
      rd(8'h28, 32'h0);
      chk("stack slot", 32'h0, sp_addr_r);
   endtask
   task automatic t_vtor();
      wr(8'h00, 32'h00001200);
      rd(8'h00, 32'h0);
      rd(8'h18, 32'h2);
      wr(8'h18, 32'h2);
      rd(8'h18, 32'h0);
      @(posedge clk);
      reg_priv <= 1'b1;
      wr(8'h00, 32'h3fffff00);
      base = 32'h3fffff00;
      rd(8'h00, base);
      chk("stack slot", base, sp_addr_r);
   endtask
   task automatic t_tie();
      wr(8'h04, 32'hffffffff);
      rd(8'h04, 32'hfffc2dbf);
      pulse(44'h43, 16'h0);
      offer(6'd16);
      take(6'd16);
      none();
      ret();
      offer(6'd17);
      take(6'd17);
      ret();
      none();
   endtask
   task automatic t_prio();
      wr(8'h20, 32'hffffffff);
      rd(8'h20, 32'h07770000);
      wr(8'h28, 32'h00000225);
      pulse(44'h3, 16'h0);
      offer(6'd17);
      take(6'd17);
      pulse(44'h4, 16'h0);
      none();
      rd(8'h18, 32'h4);
      wr(8'h1c, 32'h4);
      chk("interrupt out", 32'h1, {31'h0, irq_o});
      wr(8'h18, 32'h4);
      chk("interrupt out", 32'h0, {31'h0, irq_o});
      wr(8'h28, 32'h00000221);
      offer(6'd16);
      take(6'd16);
      rd(8'h18, 32'h1);
   endtask
   task automatic t_nmi();
      pulse(44'h0, 16'h0004);
      offer(6'd2);
      take(6'd2);
      pulse(44'h0, 16'h0008);
      none();
      ret();
      offer(6'd3);
   endtask
   initial begin
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      t_reset();
      t_vtor();
      t_tie();
      t_prio();
      t_nmi();
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      base = 32'h0;
      t_reset();
      finish_test();
   end
endmodule
bind evpu_top evpu_top_sva u_evpu_top_sva (.clk, .reset_n, .reg_addr, .reg_wr, .reg_priv,
   .sys_req_in, .exc_ack, .exc_req_r, .exc_num_r, .vec_addr_r, .sp_addr_r, .run_num_r,
   .run_valid_r);
